/* File: dca_core.sv */
// device-side driver calibration, on-die termination and bank activate logic
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module dca_core import dca_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mem_ck,
    input wire logic mem_cke,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [2:0] mem_ba,
    input wire logic [14:0] mem_addr,
    input wire logic [7:0] mem_dq_i,
    input wire logic mem_odt,
    output logic [7:0] mem_dq_o,
    output logic mem_dq_oe_n,
    output logic mem_dqs_o,
    output logic mem_dqs_n_o,
    output logic mem_dqs_oe_n,
    output logic [2:0] term_sw,
    output logic [3:0] pu_step,
    output logic [3:0] pd_step
);
    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [3:0] step_move(input logic [3:0] s, input logic up, input logic dn);
        step_move = s;
        if (up && s != STEP_MAX) begin
            step_move = s + 4'h1;
        end else if (dn && s != STEP_MIN) begin
            step_move = s - 4'h1;
        end
    endfunction

    // returns {pu_up, pu_dn, pd_up, pd_dn, reserved}
    function automatic logic [4:0] adj_decode(input logic [3:0] c);
        unique case (c)
            4'b0000: adj_decode = 5'b00000;
            4'b0001: adj_decode = 5'b10000;
            4'b0010: adj_decode = 5'b01000;
            4'b0100: adj_decode = 5'b00100;
            4'b1000: adj_decode = 5'b00010;
            4'b0101: adj_decode = 5'b10100;
            4'b0110: adj_decode = 5'b01100;
            4'b1001: adj_decode = 5'b10010;
            4'b1010: adj_decode = 5'b01010;
            default: adj_decode = 5'b00001;
        endcase
    endfunction

    // ****************************************************************
    // pin synchronisers and command clock edges
    // ****************************************************************
    logic [32:0] pin_s1_q, pin_s2_q;
    logic ck_s3_q;
    always_ff @(posedge aclk) begin
        pin_s1_q <= {mem_ck, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr, mem_dq_i, mem_odt};
        pin_s2_q <= pin_s1_q;
        ck_s3_q <= pin_s2_q[32];
    end
    logic ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s;
    logic [2:0] ba_s;
    logic [14:0] addr_s;
    logic [7:0] dq_s;
    assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, dq_s, odt_s} = pin_s2_q;
    logic ck_rise, ck_fall;
    assign ck_rise = ck_s && !ck_s3_q;
    assign ck_fall = !ck_s && ck_s3_q;

    dca_cmd_t cmd;
    always_comb begin
        cmd = CMD_NOP;
        if (ck_rise && !cs_n_s) begin
            unique case ({ras_n_s, cas_n_s, we_n_s})
                3'b011: cmd = cke_s ? CMD_ACT : CMD_NOP;
                3'b101, 3'b100: cmd = cke_s ? CMD_RW : CMD_NOP;
                3'b010: cmd = cke_s ? CMD_PRE : CMD_NOP;
                3'b000: cmd = cke_s ? CMD_MRS : CMD_NOP;
                3'b001: cmd = cke_s ? CMD_NOP : CMD_SRE;
                default: cmd = CMD_NOP;
            endcase
        end
    end
    logic emr1_wr, mr_wr;
    assign emr1_wr = (cmd == CMD_MRS) && ba_s == 3'b001;
    assign mr_wr = (cmd == CMD_MRS) && ba_s == 3'b000;

    // ****************************************************************
    // mode fields, self refresh, banks
    // ****************************************************************
    logic [2:0] al_q, cl_q, bl_q, ocd_q;
    logic sr_q;
    logic [7:0] bank_open_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            al_q <= 3'h0;
            cl_q <= 3'h3;
            bl_q <= BL_FOUR;
            ocd_q <= OCD_EXIT;
        end else if (mr_wr) begin
            bl_q <= addr_s[2:0];
            cl_q <= addr_s[6:4];
        end else if (emr1_wr) begin
            // adjust keeps the latency already programmed
            if (addr_s[9:7] != OCD_ADJ && addr_s[5:3] <= AL_LIMIT) begin
                al_q <= addr_s[5:3];
            end
            ocd_q <= addr_s[9:7];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_q <= 1'b0;
        end else if (cmd == CMD_SRE) begin
            sr_q <= 1'b1;
        end else if (cke_s) begin
            sr_q <= 1'b0;
        end
    end

    logic idle_acc;
    assign idle_acc = (cmd == CMD_RW) && !bank_open_q[ba_s];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_open_q <= 8'h00;
        end else if (cmd == CMD_ACT) begin
            bank_open_q[ba_s] <= 1'b1;
        end else if (cmd == CMD_PRE) begin
            if (addr_s[10]) begin
                bank_open_q <= 8'h00;
            end else begin
                bank_open_q[ba_s] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // adjust burst capture and step counters
    // ****************************************************************
    dca_adj_t adj_q;
    logic [3:0] wl_cnt_q;
    logic [1:0] bit_q;
    logic [3:0] code_q;
    logic code_done;
    logic [3:0] wl;
    assign wl = {1'b0, al_q} + {1'b0, cl_q} - 4'h1;
    assign code_done = adj_q == ADJ_BURST && bit_q == 2'h3 && ck_fall;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adj_q <= ADJ_IDLE;
            wl_cnt_q <= 4'h0;
            bit_q <= 2'h0;
            code_q <= 4'h0;
        end else begin
            unique case (adj_q)
                ADJ_IDLE: begin
                    if (emr1_wr && addr_s[9:7] == OCD_ADJ) begin
                        adj_q <= ADJ_WAIT;
                        wl_cnt_q <= 4'h1;
                    end
                end
                ADJ_WAIT: begin
                    if (ck_rise) begin
                        wl_cnt_q <= wl_cnt_q + 4'h1;
                        if (wl_cnt_q == wl) begin
                            // bit time zero lands on the first edge, any burst type
                            code_q[3] <= dq_s[0];
                            bit_q <= 2'h1;
                            adj_q <= ADJ_BURST;
                        end
                    end
                end
                ADJ_BURST: begin
                    if (ck_rise || ck_fall) begin
                        code_q[2'h3 - bit_q] <= dq_s[0];
                        bit_q <= bit_q + 2'h1;
                        if (bit_q == 2'h3) begin
                            adj_q <= ADJ_IDLE;
                        end
                    end
                end
                default: adj_q <= ADJ_IDLE;
            endcase
        end
    end
    logic [3:0] code_full;
    logic [4:0] dec;
    assign code_full = {code_q[3:1], dq_s[0]};
    assign dec = adj_decode(code_full);

    logic [31:0] ctrl_q;
    logic ctrl_load_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pu_step <= PU_RESET;
            pd_step <= PD_RESET;
        end else if (ctrl_load_q) begin
            pu_step <= ctrl_q[CTRL_PU_LSB +: 4];
            pd_step <= ctrl_q[CTRL_PD_LSB +: 4];
        end else if (code_done) begin
            // one setting shared by every dq and strobe driver
            pu_step <= step_move(pu_step, dec[4], dec[3]);
            pd_step <= step_move(pd_step, dec[2], dec[1]);
        end
    end

    // ****************************************************************
    // drive mode outputs
    // ****************************************************************
    logic [3:0] oit_cnt_q;
    logic [2:0] drv_mode_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oit_cnt_q <= 4'h0;
            drv_mode_q <= OCD_EXIT;
        end else if (emr1_wr && (addr_s[9:7] == OCD_DRV1 || addr_s[9:7] == OCD_DRV0 || addr_s[9:7] == OCD_EXIT)) begin
            oit_cnt_q <= OIT_CNT;
            drv_mode_q <= addr_s[9:7];
        end else if (oit_cnt_q != 4'h0) begin
            oit_cnt_q <= oit_cnt_q - 4'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_dq_o <= 8'h00;
            mem_dqs_o <= 1'b0;
            mem_dqs_n_o <= 1'b1;
            mem_dq_oe_n <= 1'b1;
            mem_dqs_oe_n <= 1'b1;
        end else if (oit_cnt_q == 4'h1) begin
            mem_dq_oe_n <= drv_mode_q == OCD_EXIT;
            mem_dqs_oe_n <= drv_mode_q == OCD_EXIT;
            mem_dq_o <= {8{drv_mode_q == OCD_DRV1}};
            mem_dqs_o <= drv_mode_q == OCD_DRV1;
            mem_dqs_n_o <= drv_mode_q != OCD_DRV1;
        end
    end

    // ****************************************************************
    // on-die termination
    // ****************************************************************
    logic [1:0] rtt_q, rtt_new_q;
    logic [3:0] mod_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rtt_q <= 2'h0;
            rtt_new_q <= 2'h0;
            mod_cnt_q <= 4'h0;
        end else if (emr1_wr) begin
            rtt_new_q <= {addr_s[6], addr_s[2]};
            mod_cnt_q <= MOD_CNT;
        end else if (mod_cnt_q == 4'h1) begin
            rtt_q <= rtt_new_q;
            mod_cnt_q <= 4'h0;
        end else if (mod_cnt_q != 4'h0) begin
            mod_cnt_q <= mod_cnt_q - 4'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || sr_q || !odt_s) begin
            term_sw <= 3'h0;
        end else begin
            // one switch set covers dq, dm and both strobe pairs
            unique case (rtt_q)
                2'h1: term_sw <= 3'b001;
                2'h2: term_sw <= 3'b010;
                2'h3: term_sw <= 3'b100;
                default: term_sw <= 3'b000;
            endcase
        end
    end

    // ****************************************************************
    // register bus slave
    // ****************************************************************
    logic aw_have_q, w_have_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [2:0] err_q;
    logic wr_go;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == REG_CTRL || awaddr_q == REG_ERR) ? 2'h0 : 2'h2;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= {16'h0, 8'h0, PD_RESET, PU_RESET};
            ctrl_load_q <= 1'b0;
        end else begin
            ctrl_load_q <= 1'b0;
            if (wr_go && awaddr_q == REG_CTRL) begin
                for (int i = 0; i < 4; i++) begin
                    if (wstrb_q[i]) begin
                        ctrl_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
                    end
                end
                ctrl_load_q <= wstrb_q[1] && wdata_q[CTRL_LOAD_BIT];
            end
        end
    end
    // set beats clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 3'h0;
        end else begin
            err_q <= (err_q & ~((wr_go && awaddr_q == REG_ERR && wstrb_q[0]) ? wdata_q[2:0] : 3'h0))
                | {code_done && dec[0], mod_cnt_q != 4'h0 && !cke_s, idle_acc};
        end
    end
    logic [31:0] stat;
    always_comb begin
        stat = 32'h0;
        stat[STAT_PU_LSB +: 4] = pu_step;
        stat[STAT_PD_LSB +: 4] = pd_step;
        stat[STAT_OCD_LSB +: 3] = ocd_q;
        stat[STAT_AL_LSB +: 3] = al_q;
        stat[STAT_RTT_LSB +: 2] = rtt_q;
        stat[STAT_SR_BIT] = sr_q;
        stat[STAT_TERM_BIT] = term_sw != 3'h0;
        stat[STAT_BANK_LSB +: 8] = bank_open_q;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= ctrl_q;
                REG_STAT: s_axi_rdata <= stat;
                REG_ERR: s_axi_rdata <= {29'h0, err_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_step_top_sat: assert property (code_done && !ctrl_load_q && dec[4] && pu_step == STEP_MAX |=> pu_step == STEP_MAX)
        else $error("pull-up step wrapped past top");
    a_step_inc_one: assert property (code_done && !ctrl_load_q && dec[2] && pd_step != STEP_MAX
        |=> pd_step == $past(pd_step) + 4'h1)
        else $error("pull-down step not raised by one");
    a_rsv_no_change: assert property (code_done && !ctrl_load_q && dec[0] |=> $stable(pu_step) && $stable(pd_step))
        else $error("reserved code moved a step");
    a_term_sr_off: assert property (sr_q |=> term_sw == 3'h0)
        else $error("termination on in self refresh");
    a_rtt_apply_time: assert property (emr1_wr ##1 (!emr1_wr)[*8] |=> rtt_q == $past(rtt_new_q, 1))
        else $error("termination value not applied in window");
    a_drive_high_pol: assert property (emr1_wr && addr_s[9:7] == OCD_DRV1 ##1 (!emr1_wr)[*2]
        |=> !mem_dq_oe_n && mem_dq_o == 8'hff && mem_dqs_o && !mem_dqs_n_o)
        else $error("drive-high outputs wrong");
    a_bank_open_act: assert property (cmd == CMD_ACT |=> bank_open_q[$past(ba_s)])
        else $error("activate did not open bank");
    a_prea_clears: assert property (cmd == CMD_PRE && addr_s[10] |=> bank_open_q == 8'h00)
        else $error("precharge all left a bank open");
    a_idle_access_err: assert property (idle_acc |=> err_q[ERR_IDLE_ACC])
        else $error("access to idle bank not flagged");
    c_adjust_done: cover property (code_done && !dec[0]);
    c_drive_low: cover property (emr1_wr && addr_s[9:7] == OCD_DRV0);
    c_rtt_update: cover property (mod_cnt_q == 4'h1);
    c_axi_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: dca_ctl_model.sv */
// controller-side model driving the memory command, data and termination pins
`timescale 1ns/1ps
module dca_ctl_model (
    output logic mem_ck,
    output logic mem_cke,
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [2:0] mem_ba,
    output logic [14:0] mem_addr,
    output logic [7:0] mem_dq,
    output logic mem_odt
);
    // ****************************************
    // link clock stands low between frames
    // ****************************************
    initial begin
        {mem_ck, mem_odt, mem_ba, mem_addr, mem_dq} = '0;
        {mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = 5'h1f;
    end
    // pins move by non-blocking assignment, so a change on an aclk edge never races the sampling flops
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a, input logic ke);
        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr, mem_cke} <= {c, b, a, ke};
        #40 mem_ck <= 1'h1;
        // with mem_cs_n high, bank and address lines show the inverse; mem_ras_n, mem_cas_n and mem_we_n keep their value
        #20 {mem_cs_n, mem_ba, mem_addr} <= {1'h1, ~b, ~a};
        #20 mem_ck <= 1'h0;
    endtask
    task automatic adj(input logic [3:0] code, input logic [14:0] a, input int wl);
        int i;
        cmd(4'h0, 3'h1, a | 15'h0200, 1'h1);
        repeat (wl - 1) begin
            #40 mem_ck <= 1'h1;
            #40 mem_ck <= 1'h0;
        end
        for (i = 3; i >= 0; i--) begin
            #20 mem_dq <= {8{code[i]}};
            #20 mem_ck <= ~mem_ck;
        end
        #20 mem_dq <= ~mem_dq;
        #60 cmd(4'h0, 3'h1, a, 1'h1);
    endtask
endmodule

/* File: dca_pkg.sv */
// constants, codes and types for the calibration, termination and activate block
// ****************************************************************
// ****************************************************************
package dca_pkg;
    // register map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_ERR = 4'h8;
    // ctrl fields
    localparam int CTRL_PU_LSB = 0;
    localparam int CTRL_PD_LSB = 4;
    localparam int CTRL_LOAD_BIT = 8;
    // status fields
    localparam int STAT_PU_LSB = 0;
    localparam int STAT_PD_LSB = 4;
    localparam int STAT_OCD_LSB = 8;
    localparam int STAT_AL_LSB = 11;
    localparam int STAT_RTT_LSB = 14;
    localparam int STAT_SR_BIT = 16;
    localparam int STAT_TERM_BIT = 17;
    localparam int STAT_BANK_LSB = 24;
    // error flags
    localparam int ERR_IDLE_ACC = 0;
    localparam int ERR_CKE_MOD = 1;
    localparam int ERR_RSV_CODE = 2;
    // impedance steps
    localparam logic [3:0] STEP_MAX = 4'hf;
    localparam logic [3:0] STEP_MIN = 4'h0;
    localparam logic [3:0] PU_RESET = 4'h8;
    localparam logic [3:0] PD_RESET = 4'h8;
    // calibration field codes, address bits 9..7, then the latency limit and burst length codes
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] OCD_DRV1 = 3'h1;
    localparam logic [2:0] OCD_DRV0 = 3'h2;
    localparam logic [2:0] OCD_ADJ = 3'h4;
    localparam logic [2:0] OCD_DFLT = 3'h7;
    localparam logic [2:0] AL_LIMIT = 3'h6;
    localparam logic [2:0] BL_FOUR = 3'h2;
    // timing
    localparam int CLK_PS = 5000;
    localparam int T_OIT_NS = 2;
    localparam int T_MOD_MIN_NS = 12;
    localparam int OIT_CYC = (T_OIT_NS * 1000 + CLK_PS - 1) / CLK_PS < 1 ? 1 :
                             (T_OIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int MOD_CYC = (T_MOD_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam logic [3:0] OIT_CNT = 4'(OIT_CYC);
    localparam logic [3:0] MOD_CNT = 4'(MOD_CYC);
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000, CMD_ACT = 3'b001, CMD_RW = 3'b010, CMD_PRE = 3'b011,
        CMD_MRS = 3'b100, CMD_SRE = 3'b101
    } dca_cmd_t;
    typedef enum logic [1:0] {
        ADJ_IDLE = 2'b00, ADJ_WAIT = 2'b01, ADJ_BURST = 2'b10
    } dca_adj_t;
endpackage

/* File: ddr2_calibration_termination_activate_tb_top.sv */
// self-checking bench for the calibration, termination and activate block
`timescale 1ns/1ps
module ddr2_calibration_termination_activate_tb_top;
    import dca_pkg::*;
    localparam int WL = 3;
    localparam logic [14:0] EMR_AL = 15'h0008;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, pu_step, pd_step, c;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, h;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic mem_ck, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_odt;
    logic mem_dq_oe_n, mem_dqs_o, mem_dqs_n_o, mem_dqs_oe_n;
    logic [2:0] mem_ba, term_sw;
    logic [14:0] mem_addr;
    logic [7:0] mem_dq, mem_dq_o;
    int n_errors = 0, n_checks = 0, cyc = 0, pu, pd, i;

    dca_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_ck, .mem_cke, .mem_cs_n,
        .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_addr, .mem_dq_i(mem_dq), .mem_odt, .mem_dq_o,
        .mem_dq_oe_n, .mem_dqs_o, .mem_dqs_n_o, .mem_dqs_oe_n, .term_sw, .pu_step, .pd_step);
    dca_ctl_model ctl (.mem_ck, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_addr,
        .mem_dq, .mem_odt);

    // ****************************************
    // clock, timeout and bus tasks
    // ****************************************
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        {r, v} = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'h0;
    endtask
    // saturating step model of the adjust code table
    task automatic exp_adj(input logic [3:0] k);
        int u, d;
        case (k)
            4'h1, 4'h5, 4'h9: u = 1;
            4'h2, 4'h6, 4'ha: u = -1;
            default: u = 0;
        endcase
        case (k)
            4'h4, 4'h5, 4'h6: d = 1;
            4'h8, 4'h9, 4'ha: d = -1;
            default: d = 0;
        endcase
        pu = (pu + u > 15) ? 15 : (pu + u < 0) ? 0 : pu + u;
        pd = (pd + d > 15) ? 15 : (pd + d < 0) ? 0 : pd + d;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        chk("reset", 32'({PU_RESET, PD_RESET, 5'h3}), 32'({pu_step, pd_step, term_sw, mem_dq_oe_n, mem_dqs_oe_n}));
        ctl.cmd(4'h0, 3'h0, 15'h0032, 1'h1);
        ctl.cmd(4'h0, 3'h1, EMR_AL, 1'h1);
        wr(4'hc, 32'h0);
        chk("bresp unmapped", 32'h2, 32'(r));
        wr(REG_STAT, 32'h0);
        chk("bresp stat", 32'h2, 32'(r));
        rd(4'hc);
        chk("rresp unmapped", 32'h2, 32'(r));
        wr(REG_CTRL, 32'h1c3);
        rd(REG_CTRL);
        chk("ctrl", 32'h1c3, v);
        rd(REG_STAT);
        chk("stat al", 32'h1, 32'(v[13:11]));
        pu = 3;
        pd = 12;
        for (i = 0; i < 18; i++) begin
            if (i > 15) begin
                pu = (i == 16) ? 15 : 0;
                pd = pu;
                wr(REG_CTRL, (i == 16) ? 32'h1ff : 32'h100);
            end
            c = (i == 16) ? 4'h5 : (i == 17) ? 4'ha : 4'(i);
            ctl.adj(c, EMR_AL, WL);
            exp_adj(c);
            chk("steps", 32'({4'(pu), 4'(pd)}), 32'({pu_step, pd_step}));
        end
        rd(REG_ERR);
        chk("err reserved", 32'h4, v);
        wr(REG_ERR, 32'h7);
        for (i = 1; i < 3; i++) begin
            h = (i == 1);
            ctl.cmd(4'h0, 3'h1, EMR_AL | 15'(i << 7), 1'h1);
            v = 32'({mem_dq_oe_n, mem_dqs_oe_n, mem_dq_o, mem_dqs_o, mem_dqs_n_o});
            chk("drive", 32'({2'h0, {8{h}}, h, !h}), v);
            ctl.cmd(4'h0, 3'h1, EMR_AL, 1'h1);
            chk("drive off", 32'h3, 32'({mem_dq_oe_n, mem_dqs_oe_n}));
        end
        for (i = 1; i < 4; i++) begin
            ctl.mem_odt <= 1'h0;
            repeat (10) @(posedge aclk);
            chk("term off", 32'h0, 32'(term_sw));
            ctl.cmd(4'h0, 3'h1, EMR_AL | {8'h0, i[1], 3'h0, i[0], 2'h0}, 1'h1);
            ctl.mem_odt <= 1'h1;
            repeat (10) @(posedge aclk);
            chk("term_sw", 32'(3'h1 << (i - 1)), 32'(term_sw));
        end
        ctl.mem_odt <= 1'h0;
        ctl.cmd(4'h1, 3'h0, 15'h0, 1'h0);
        ctl.mem_odt <= 1'h1;
        repeat (10) @(posedge aclk);
        chk("term self refresh", 32'h0, 32'(term_sw));
        ctl.cmd(4'h7, 3'h0, 15'h0, 1'h1);
        repeat (10) @(posedge aclk);
        chk("term after exit", 32'h4, 32'(term_sw));
        ctl.mem_odt <= 1'h0;
        ctl.cmd(4'h3, 3'h2, 15'h0123, 1'h1);
        ctl.cmd(4'h3, 3'h6, 15'h0044, 1'h1);
        ctl.cmd(4'h5, 3'h2, 15'h0000, 1'h1);
        rd(REG_ERR);
        chk("err after access", 32'h0, v);
        rd(REG_STAT);
        chk("open banks", 32'h44, 32'(v[31:24]));
        ctl.cmd(4'h5, 3'h5, 15'h0000, 1'h1);
        ctl.cmd(4'h2, 3'h0, 15'h0400, 1'h1);
        rd(REG_ERR);
        chk("err idle bank", 32'h1, v);
        rd(REG_STAT);
        chk("banks closed", 32'h0, 32'(v[31:24]));
        ctl.cmd(4'h3, 3'h2, 15'h0123, 1'h1);
        rd(REG_STAT);
        chk("bank reopened", 32'h4, 32'(v[31:24]));
        complete_run();
    end
endmodule
